//--- flash_reg_cmd_map.svh
`ifndef FLASH_REG_CMD_MAP_SVH
`define FLASH_REG_CMD_MAP_SVH

// opcodes
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_STATUS_ALT 8'h31
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_ENABLE 8'h06
`define OP_READ_STATUS_LO 8'h05
`define OP_READ_STATUS_HI 8'h35
`define OP_READ_CONFIG 8'h15
`define OP_WRITE_CONFIG 8'h11
`define OP_READ_DATA 8'h03

// frame lengths in serial clocks, opcode included
`define BITS_OPCODE 7'h08
`define BITS_DATA8 7'h10
`define BITS_DATA16 7'h18
`define BITS_ADDRESS 7'h20

// configuration register
`define CFG_RESET 8'h00
`define CFG_WRITE_MASK 8'hE6

// status register
`define SR_RESET 16'h0000
`define SR_BUSY 0
`define SR_WEL 1
`define SR_STATUS_PROTECT_LO 7
`define SR_STATUS_PROTECT_HI 8
`define SR_QE 9
`define SR_KEEP_MASK 16'h8403
`define SR_OTP_MASK 16'h3800

// dummy clocks per read form
`define DUMMY_DUAL_DC0 4'h4
`define DUMMY_DUAL_DC1 4'h8
`define DUMMY_QUAD_DC0 4'h6
`define DUMMY_QUAD_DC1 4'hA

// timing
`define CLK_MHZ 100
`define STATUS_WRITE_TIME_NS 1000000
`define STATUS_WRITE_CYCLES ((`STATUS_WRITE_TIME_NS * `CLK_MHZ + 999) / 1000)

// array contents after reset
`define MEM_FILL 8'hFF

`endif

//--- flash_reg_cmd_pkg.sv
package flash_reg_cmd_pkg;

   typedef enum logic [0:0] {
      W_IDLE = 1'b0,
      W_BUSY = 1'b1
   } wstate_t;

   typedef struct packed {
      logic mfpReset;
      logic [1:0] drive;
      logic [1:0] rsvHi;
      logic protect_scheme_select;
      logic dc;
      logic rsvLo;
   } config_t;

   typedef struct packed {
      logic holdEn;
      logic resetEn;
   } pin_role_t;

   typedef logic [3:0] dummy_t;

endpackage : flash_reg_cmd_pkg

//--- flash_reg_cmd_and_read.sv
`timescale 1ns/1ns
`include "flash_reg_cmd_map.svh"

// How it works
// R1 - configuration read answers at any time, even while busy
// R2 - configuration read: opcode in, byte out on serial output; upper lanes unused
// R3 - config bit 7 picks pause role at zero, reset role at one
// R4 - quad enable set disables both pin roles, pin is data only
// R5 - config bits 6:5 select drive: 100, 75, 125, 150 percent
// R6 - config bit 2 picks range protection or per-block lock protection
// R7 - every block lock bit is one after power-on and any reset
// R8 - config bit 1 picks dummy clocks: dual 4/8, quad 6/10
// R9 - status write refused unless write-enable latch is set
// R10 - status write never changes suspend, fail, latch or busy bits
// R11 - status write executes only if select rises after 8 or 16 bits
// R12 - eight-bit status write updates low byte, keeps high byte
// R13 - valid status write starts timed cycle; end clears busy and latch
// R14 - status reads still served while the write cycle runs
// R15 - hardware protected mode ignores status writes
// R16 - opcodes 01h and 31h both write status, 01h takes two bytes
// R17 - config write needs latch and exactly eight data bits
// R18 - valid config write starts timed cycle; end clears busy and latch
// R19 - read samples address on rising edges, shifts data on falling edges
// R20 - read takes 3-byte address, streams until select rises
// R21 - read address steps after each byte, wraps to zero
// R22 - write-enable latch at status bit 1 gates all writes
// R23 - busy flag at status bit 0, high during any write cycle
// R24 - reserved config bits 4, 3, 0 read zero, writes ignored
// R25 - host waits for busy low before the next write
module flash_reg_cmd_and_read #(
   parameter int WRITE_CYCLES = `STATUS_WRITE_CYCLES,
   parameter int ADDR_W = 24,
   parameter int MEM_IDX_W = 8,
   parameter int LOCK_COUNT = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic sclk,
   input wire logic csN,
   input wire logic si,
   output logic so,
   output logic soOe,
   input wire logic wpN,
   input wire logic mfpN,
   input wire logic memLoadEn,
   input wire logic [MEM_IDX_W-1:0] memLoadAddr,
   input wire logic [7:0] memLoadData,
   output logic busyFlag,
   output logic writeEnableLatch,
   output logic [1:0] driveStrength,
   output logic protectSchemeSelect,
   output flash_reg_cmd_pkg::pin_role_t pinRole,
   output flash_reg_cmd_pkg::dummy_t dualDummyCount,
   output flash_reg_cmd_pkg::dummy_t quadDummyCount,
   output logic [LOCK_COUNT-1:0] blockLocks
);
   import flash_reg_cmd_pkg::*;

   localparam int MEM_DEPTH = 1 << MEM_IDX_W;

   ////////////////////////////////////////////////////////////////////////////
   // array storage, loaded from the clk side

   logic [7:0] mem_q [MEM_DEPTH];

   generate
      for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
         always_ff @(posedge clk) begin
            if (rst) begin
               mem_q[i] <= `MEM_FILL;
            end else if (ce && memLoadEn && memLoadAddr == MEM_IDX_W'(i)) begin
               mem_q[i] <= memLoadData;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // link side, serial clock domain

   logic [6:0] bitCnt_q;
   logic [6:0] bitCnt_d;
   logic [6:0] frameBits_q;
   logic [23:0] shift_q;
   logic [7:0] opcode_q;
   logic frameTog_q;
   logic [2:0] bitIdx_q;
   logic [ADDR_W-1:0] rdAddr_q;
   logic [23:0] regSync1_q;
   logic [23:0] regSync2_q;
   logic so_q;
   logic soOe_q;
   logic [23:0] pub_q;

   wire linkClear = csN | rst;
   wire [23:0] shiftIn = {shift_q[22:0], si};
   wire opcodeDone = bitCnt_q == (`BITS_OPCODE - 7'h01);
   wire addrDone = bitCnt_q == (`BITS_ADDRESS - 7'h01);
   wire isRead = opcode_q == `OP_READ_DATA;
   wire readPhase = isRead && bitCnt_q >= `BITS_ADDRESS;
   wire isRegRead = opcode_q == `OP_READ_STATUS_LO || opcode_q == `OP_READ_STATUS_HI ||
      opcode_q == `OP_READ_CONFIG;
   wire regPhase = isRegRead && bitCnt_q >= `BITS_OPCODE;
   wire txActive = readPhase || regPhase;
   wire [7:0] memByte = mem_q[rdAddr_q[MEM_IDX_W-1:0]];
   wire [7:0] regByte = (opcode_q == `OP_READ_STATUS_LO) ? regSync2_q[15:8] :
      (opcode_q == `OP_READ_STATUS_HI) ? regSync2_q[23:16] : regSync2_q[7:0];
   wire [7:0] txByte = isRead ? memByte : regByte;

   assign bitCnt_d = (bitCnt_q == 7'h7F) ? bitCnt_q : bitCnt_q + 7'h01;

   // frame position ends with the frame itself
   always_ff @(posedge sclk or posedge linkClear) begin
      if (linkClear) begin
         bitCnt_q <= 7'h00;
      end else begin
         bitCnt_q <= bitCnt_d;
      end
   end

   // one toggle per started frame tells the clk side a frame is new
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         frameTog_q <= 1'b0;
      end else if (!csN && bitCnt_q == 7'h00) begin
         frameTog_q <= ~frameTog_q;
      end
   end

   // these hold still once select is high, so the clk side may read them
   always_ff @(posedge sclk) begin
      shift_q <= shiftIn; // R19
      frameBits_q <= bitCnt_d;
      regSync1_q <= pub_q;
      regSync2_q <= regSync1_q; // R14
      if (opcodeDone) begin
         opcode_q <= shiftIn[7:0];
      end
   end

   // read pointer, rising edge
   always_ff @(posedge sclk) begin
      if (opcodeDone || addrDone) begin
         bitIdx_q <= 3'h0;
      end else begin
         bitIdx_q <= bitIdx_q + 3'h1;
      end
      if (addrDone) begin
         rdAddr_q <= shiftIn[ADDR_W-1:0]; // R20
      end else if (readPhase && bitIdx_q == 3'h7) begin
         rdAddr_q <= rdAddr_q + ADDR_W'(1); // R21
      end
   end

   // falling edge launch gives the host a full half period of setup
   always_ff @(negedge sclk or posedge linkClear) begin
      if (linkClear) begin
         so_q <= 1'b0;
         soOe_q <= 1'b0;
      end else begin
         so_q <= txByte[3'h7 - bitIdx_q]; // R19
         soOe_q <= txActive; // R2
      end
   end

   assign so = so_q;
   assign soOe = soOe_q;

   ////////////////////////////////////////////////////////////////////////////
   // clk domain: pin synchronisers

   logic csS1_q, csS2_q, csPrev_q;
   logic togS1_q, togS2_q, togSeen_q;
   logic wpS1_q, wpS2_q;
   logic mfpS1_q, mfpS2_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         csS1_q <= 1'b1;
         csS2_q <= 1'b1;
         csPrev_q <= 1'b1;
         togS1_q <= 1'b0;
         togS2_q <= 1'b0;
         togSeen_q <= 1'b0;
         wpS1_q <= 1'b1;
         wpS2_q <= 1'b1;
         mfpS1_q <= 1'b1;
         mfpS2_q <= 1'b1;
      end else if (ce) begin
         csS1_q <= csN;
         csS2_q <= csS1_q;
         csPrev_q <= csS2_q;
         togS1_q <= frameTog_q;
         togS2_q <= togS1_q;
         if (csS2_q && !csPrev_q) begin
            togSeen_q <= togS2_q;
         end
         wpS1_q <= wpN;
         wpS2_q <= wpS1_q;
         mfpS1_q <= mfpN;
         mfpS2_q <= mfpS1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clk domain: command decode at end of frame

   wstate_t state_q;
   wstate_t state_d;
   logic [31:0] timer_q;
   logic [15:0] stat_q;
   config_t cfg_q;
   logic wel_q;
   logic busy_q;
   logic [LOCK_COUNT-1:0] locks_q;
   pin_role_t role_q;
   dummy_t dualDummy_q;
   dummy_t quadDummy_q;

   wire frameEnd = csS2_q && !csPrev_q && (togS2_q != togSeen_q);
   wire isBusy = state_q == W_BUSY;
   wire qe = stat_q[`SR_QE];
   wire [1:0] srp = {stat_q[`SR_STATUS_PROTECT_HI], stat_q[`SR_STATUS_PROTECT_LO]};
   // lockdown and one-time modes also refuse status writes
   wire hwProtect = srp[1] || (srp == 2'b01 && !wpS2_q && !qe); // R15
   wire isStatusOp = opcode_q == `OP_WRITE_STATUS || opcode_q == `OP_WRITE_STATUS_ALT; // R16
   wire statusLen8 = frameBits_q == `BITS_DATA8;
   wire statusLen16 = frameBits_q == `BITS_DATA16;
   wire statusWrite = frameEnd && isStatusOp && (statusLen8 || statusLen16) && // R11
      wel_q && !isBusy && !hwProtect; // R9 R22
   wire configWrite = frameEnd && opcode_q == `OP_WRITE_CONFIG &&
      frameBits_q == `BITS_DATA8 && wel_q && !isBusy; // R17 R22
   wire opOnly = frameEnd && frameBits_q == `BITS_OPCODE && !isBusy;
   wire wrenCmd = opOnly && opcode_q == `OP_WRITE_ENABLE;
   wire wrdiCmd = opOnly && opcode_q == `OP_WRITE_DISABLE;
   wire cycleDone = isBusy && timer_q == 32'(WRITE_CYCLES - 1);
   wire pinReset = cfg_q.mfpReset && !qe && !mfpS2_q; // R3 R4

   // first data byte is the low status byte, second the high one
   wire [15:0] statusIn = statusLen16 ? {shift_q[7:0], shift_q[15:8]} :
      {stat_q[15:8], shift_q[7:0]}; // R12
   wire [15:0] statusNew = (statusIn & ~`SR_KEEP_MASK) | (stat_q & `SR_KEEP_MASK) |
      (stat_q & `SR_OTP_MASK); // R10
   wire [7:0] configNew = shift_q[7:0] & `CFG_WRITE_MASK; // R24

   always_comb begin
      state_d = state_q;
      case (state_q)
         W_IDLE: begin
            if (statusWrite || configWrite) begin
               state_d = W_BUSY; // R13 R18
            end
         end
         W_BUSY: begin
            if (cycleDone) begin
               state_d = W_IDLE;
            end
         end
         default: begin
            state_d = W_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst || (ce && pinReset)) begin
         state_q <= W_IDLE;
         timer_q <= 32'h0000_0000;
         busy_q <= 1'b0;
         wel_q <= 1'b0;
         locks_q <= '1; // R7
      end else if (ce) begin
         state_q <= state_d;
         busy_q <= state_d == W_BUSY; // R23
         timer_q <= isBusy ? timer_q + 32'h0000_0001 : 32'h0000_0000;
         if (wrenCmd) begin
            wel_q <= 1'b1;
         end else if (cycleDone || wrdiCmd) begin
            wel_q <= 1'b0; // R13 R18
         end
      end
   end

   // register contents; power-on reset loads SR_RESET and CFG_RESET, pin reset only clears the dc bit
   always_ff @(posedge clk) begin
      if (rst) begin
         stat_q <= `SR_RESET;
         cfg_q <= `CFG_RESET;
      end else if (ce) begin
         if (pinReset) begin
            cfg_q.dc <= 1'b0;
         end else if (statusWrite) begin
            stat_q <= statusNew;
         end else if (configWrite) begin
            cfg_q <= configNew;
         end
      end
   end

   // published copy feeds the link side synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         pub_q <= {`SR_RESET, `CFG_RESET};
      end else if (ce) begin
         pub_q <= {stat_q[15:2], wel_q, busy_q, cfg_q}; // R1 R14 R22 R23
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration effects

   always_ff @(posedge clk) begin
      if (rst) begin
         role_q <= '0;
         dualDummy_q <= `DUMMY_DUAL_DC0;
         quadDummy_q <= `DUMMY_QUAD_DC0;
      end else if (ce) begin
         role_q.holdEn <= !qe && !cfg_q.mfpReset; // R3 R4
         role_q.resetEn <= !qe && cfg_q.mfpReset; // R3 R4
         dualDummy_q <= cfg_q.dc ? `DUMMY_DUAL_DC1 : `DUMMY_DUAL_DC0; // R8
         quadDummy_q <= cfg_q.dc ? `DUMMY_QUAD_DC1 : `DUMMY_QUAD_DC0; // R8
      end
   end

   assign busyFlag = busy_q;
   assign writeEnableLatch = wel_q;
   assign driveStrength = cfg_q.drive; // R5
   assign protectSchemeSelect = cfg_q.protect_scheme_select; // R6
   assign pinRole = role_q;
   assign dualDummyCount = dualDummy_q;
   assign quadDummyCount = quadDummy_q;
   assign blockLocks = locks_q;

endmodule : flash_reg_cmd_and_read

//--- flash_reg_cmd_checker.sv
`timescale 1ns/1ns
module flash_reg_cmd_checker
   import flash_reg_cmd_pkg::*;
#(
   parameter int LOCK_COUNT = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic so,
   input wire logic soOe,
   input wire logic busyFlag,
   input wire logic writeEnableLatch,
   input wire flash_reg_cmd_pkg::pin_role_t pinRole,
   input wire flash_reg_cmd_pkg::dummy_t dualDummyCount,
   input wire flash_reg_cmd_pkg::dummy_t quadDummyCount,
   input wire logic [LOCK_COUNT-1:0] blockLocks
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   busy_end_a: assert property ($fell(busyFlag) |-> !writeEnableLatch)
      else $error("latch still set after write cycle");
   busy_len_a: assert property ($rose(busyFlag) |-> busyFlag [*8])
      else $error("write cycle too short");
   busy_wel_a: assert property ($rose(busyFlag) |-> writeEnableLatch)
      else $error("write cycle without latch");
   busy_cs_a: assert property ($rose(busyFlag) |-> csN && $past(csN, 2))
      else $error("write cycle began inside a frame");
   lock_reset_a: assert property ($past(rst) |-> &blockLocks)
      else $error("block locks not set after reset");
   dummy_map_a: assert property ((dualDummyCount == 4'h4 && quadDummyCount == 4'h6) ||
      (dualDummyCount == 4'h8 && quadDummyCount == 4'hA))
      else $error("dummy counts inconsistent");
   pin_role_a: assert property (!(pinRole.holdEn && pinRole.resetEn))
      else $error("both pin roles active");
   so_idle_a: assert property (csN |-> !soOe && !so)
      else $error("serial output driven while deselected");
   cover property ($fell(busyFlag));
   cover property (soOe);
   cover property (pinRole.resetEn);
endmodule : flash_reg_cmd_checker
bind flash_reg_cmd_and_read flash_reg_cmd_checker #(.LOCK_COUNT(LOCK_COUNT)) chk_i (.clk(clk), .rst(rst),
   .csN(csN), .so(so), .soOe(soOe), .busyFlag(busyFlag), .writeEnableLatch(writeEnableLatch),
   .pinRole(pinRole), .dualDummyCount(dualDummyCount), .quadDummyCount(quadDummyCount), .blockLocks(blockLocks));

//--- host_serial_model.sv
`timescale 1ns/1ns
module host_serial_model (
   output logic sclk,
   output logic csN,
   output logic si,
   input wire logic so
);
   // link clock stands still low between frames
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      si = 1'b0;
   end
   // mode 0, msb first; so captured at each rising edge
   task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = '0;
      csN = 1'b0;
      for (int i = 0; i < n; i++) begin
         si = tx[63-i];
         #6 sclk = 1'b1;
         rx = {rx[62:0], so};
         #6 sclk = 1'b0;
      end
      #6 csN = 1'b1;
      si = ~si; // no stale level once released
   endtask : xfer
endmodule : host_serial_model

//--- tb_flash_reg_cmd_and_read.sv
`timescale 1ns/1ns
module tb_flash_reg_cmd_and_read;
   import flash_reg_cmd_pkg::*;
   logic clk = 1'b0, rst, ce, sclk, csN, si, so, soOe, wpN, mfpN, memLoadEn, busyFlag, writeEnableLatch;
   logic [7:0] memLoadAddr, memLoadData;
   logic [1:0] driveStrength;
   logic protectSchemeSelect;
   pin_role_t pinRole;
   dummy_t dualDummyCount, quadDummyCount;
   logic [15:0] blockLocks;
   logic [63:0] rx;
   int fail_count = 0, n_compared = 0, cycles = 0;
   always #5 clk = ~clk;
   // short write cycle keeps the run brief
   flash_reg_cmd_and_read #(.WRITE_CYCLES(40)) flash_reg_cmd_and_read_i (.clk(clk), .rst(rst), .ce(ce),
      .sclk(sclk), .csN(csN), .si(si), .so(so), .soOe(soOe), .wpN(wpN), .mfpN(mfpN), .memLoadEn(memLoadEn),
      .memLoadAddr(memLoadAddr), .memLoadData(memLoadData), .busyFlag(busyFlag),
      .writeEnableLatch(writeEnableLatch), .driveStrength(driveStrength),
      .protectSchemeSelect(protectSchemeSelect), .pinRole(pinRole), .dualDummyCount(dualDummyCount),
      .quadDummyCount(quadDummyCount), .blockLocks(blockLocks));
   host_serial_model host_i (.sclk(sclk), .csN(csN), .si(si), .so(so));
   ////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
         fail_count++;
      end
   endtask : chk
   task automatic frame(input logic [7:0] op, input logic [23:0] d, input int n);
      host_i.xfer({op, d, 32'h0000_0000}, n, rx);
      repeat (6) @(posedge clk);
   endtask : frame
   task automatic load(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      memLoadEn <= 1'b1;
      memLoadAddr <= a;
      memLoadData <= d;
      @(posedge clk);
      memLoadEn <= 1'b0;
   endtask : load
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      wpN = 1'b1;
      mfpN = 1'b1;
      memLoadEn = 1'b0;
      memLoadAddr = 8'h00;
      memLoadData = 8'h00;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(16'({busyFlag, writeEnableLatch, driveStrength, protectSchemeSelect}), 16'h0000);
      chk(16'({pinRole, dualDummyCount, quadDummyCount}), 16'h0246);
      chk(blockLocks, 16'hFFFF);
      frame(8'h15, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h0000);
      $display("reset test done");
      // refused writes: no latch, then wrong lengths
      frame(8'h11, 24'hFF_0000, 16);
      chk(16'(busyFlag), 16'h0000);
      frame(8'h06, 24'h00_0000, 8);
      chk(16'(writeEnableLatch), 16'h0001);
      frame(8'h11, 24'hFF_0000, 15);
      frame(8'h01, 24'hFF_0000, 20);
      chk(16'({busyFlag, writeEnableLatch}), 16'h0001);
      frame(8'h11, 24'hFF_0000, 16);
      chk(16'(busyFlag), 16'h0001);
      frame(8'h05, 24'h00_0000, 16);
      chk(16'(rx[1:0]), 16'h0003);
      repeat (60) @(posedge clk);
      chk(16'({busyFlag, writeEnableLatch}), 16'h0000);
      frame(8'h15, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h00E6);
      chk(16'({driveStrength, protectSchemeSelect, pinRole, dualDummyCount, quadDummyCount}), 16'h1D8A);
      @(posedge clk);
      mfpN <= 1'b0;
      repeat (5) @(posedge clk);
      mfpN <= 1'b1;
      repeat (4) @(posedge clk);
      chk(16'(dualDummyCount), 16'h0004);
      chk(blockLocks, 16'hFFFF);
      $display("config test done");
      // status write, eight data bits
      frame(8'h06, 24'h00_0000, 8);
      frame(8'h01, 24'hFF_0000, 16);
      chk(16'(busyFlag), 16'h0001);
      repeat (60) @(posedge clk);
      chk(16'({busyFlag, writeEnableLatch}), 16'h0000);
      frame(8'h05, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h00FC);
      frame(8'h35, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h0000);
      // protect pin low with status protect bit set
      @(posedge clk);
      wpN <= 1'b0;
      repeat (4) @(posedge clk);
      frame(8'h06, 24'h00_0000, 8);
      frame(8'h01, 24'h00_0000, 16);
      chk(16'(busyFlag), 16'h0000);
      frame(8'h05, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h00FE);
      @(posedge clk);
      wpN <= 1'b1;
      repeat (4) @(posedge clk);
      frame(8'h31, 24'h00_0200, 24);
      chk(16'(busyFlag), 16'h0001);
      repeat (60) @(posedge clk);
      frame(8'h35, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h0002);
      frame(8'h05, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h0000);
      // short write must leave a nonzero high byte alone
      frame(8'h06, 24'h00_0000, 8);
      frame(8'h01, 24'h04_0000, 16);
      repeat (60) @(posedge clk);
      frame(8'h35, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h0002);
      frame(8'h05, 24'h00_0000, 16);
      chk(16'(rx[7:0]), 16'h0004);
      chk(16'(pinRole), 16'h0000);
      $display("status test done");
      // read across the top of the address space
      load(8'hFE, 8'hA5);
      load(8'hFF, 8'h5A);
      load(8'h00, 8'h3C);
      frame(8'h03, 24'hFF_FFFE, 56);
      chk(rx[23:8], 16'hA55A);
      chk(16'(rx[7:0]), 16'h003C);
      $display("read test done");
      wrap_up();
   end
endmodule : tb_flash_reg_cmd_and_read
